/* design/sol_defs.svh */
// Offsets, strap pin indexes, field positions and reset values of the strap latch
`ifndef SOL_DEFS_SVH
`define SOL_DEFS_SVH

// Strap pin indexes on the shared pin vectors
`define SOL_NPIN 12
`define SOL_PIN_ADDR_LO 0
`define SOL_PIN_ADDR_HI 2
`define SOL_PIN_MODE_LO 3
`define SOL_PIN_MODE_HI 5
`define SOL_PIN_NEG 6
`define SOL_PIN_TREE 7
`define SOL_PIN_FILT 8
`define SOL_PIN_SPD 9
`define SOL_PIN_DPX 10
`define SOL_PIN_BCST 11

// Register offsets
`define SOL_REG_CTRL 5'h00
`define SOL_REG_ADV 5'h04

// Control register fields
`define SOL_CTRL_SPD 13
`define SOL_CTRL_NEG 12
`define SOL_CTRL_DPX 8

// Advertisement: 100 Mbps ability bits and the rest of the word
`define SOL_ADV_100_MASK 16'h0180
`define SOL_ADV_BASE 16'h0061

// Values that match the internal pulls with no board straps
`define SOL_ADDR_DEF 3'h1
`define SOL_MODE_DEF 3'h0
`define SOL_CTRL_RST 16'h3000
`define SOL_ADV_RST 16'h01E1

// Mode codes and special address
`define SOL_MODE_MDIX_A 3'h2
`define SOL_MODE_MDIX_B 3'h6
`define SOL_BCAST_ADDR 5'h00
`define SOL_ADDR_UPPER 2'h0

`endif

/* design/sol_pkg.sv */
// Types shared by the strap option latch
package sol_pkg;
  typedef enum {SOL_ST_RESET, SOL_ST_RUN} sol_state_t;
  typedef logic [15:0] sol_word_t;
  typedef logic [4:0] sol_addr_t;
endpackage : sol_pkg

/* design/sol_top.sv */
// Strap option latch: samples shared strap pins at chip reset release
`timescale 1ns/10ps
`include "sol_defs.svh"

module sol_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic chip_reset_n_i,
  input wire logic [`SOL_NPIN-1:0] strap_pin_i,
  output logic [`SOL_NPIN-1:0] strap_pin_o,
  output logic [`SOL_NPIN-1:0] strap_pin_oe_o,
  input wire logic [`SOL_NPIN-1:0] func_out_i,
  input wire logic mgmt_valid_i,
  input wire logic mgmt_write_i,
  input wire logic [4:0] mgmt_phy_i,
  input wire logic [4:0] mgmt_reg_i,
  input wire logic [15:0] mgmt_wdata_i,
  output logic mgmt_ack_o,
  output logic [15:0] mgmt_rdata_o,
  output logic [4:0] mgmt_addr_o,
  output logic [2:0] mode_o,
  output logic mode_reserved_o,
  output logic mdix_en_o,
  output logic test_tree_en_o,
  output logic filter_dis_o,
  output logic bcast_en_o,
  output logic [15:0] basic_control_o,
  output logic [15:0] negotiation_advertisement_o
);

  // Chip reset pin synchroniser
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= chip_reset_n_i;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Strap pin synchronisers, left unreset so they are full by the time
  // the reset synchroniser can first report a release
  logic [`SOL_NPIN-1:0] pin_s1_r;
  logic [`SOL_NPIN-1:0] pin_s2_r;
  genvar gi;
  generate
    for (gi = 0; gi < `SOL_NPIN; gi++) begin : g_pin_sync
      always_ff @(posedge clk_i) begin
        pin_s1_r[gi] <= strap_pin_i[gi];
        pin_s2_r[gi] <= pin_s1_r[gi];
      end
    end
  endgenerate

  // Chip state follows the synchronised reset pin
  sol_pkg::sol_state_t state_r;
  sol_pkg::sol_state_t state_nxt;
  logic release_w;

  assign release_w = (state_r == sol_pkg::SOL_ST_RESET) && rst_s2_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sol_pkg::SOL_ST_RESET: begin
        if (rst_s2_r) begin
          state_nxt = sol_pkg::SOL_ST_RUN;
        end
      end
      sol_pkg::SOL_ST_RUN: begin
        if (!rst_s2_r) begin
          state_nxt = sol_pkg::SOL_ST_RESET;
        end
      end
      default: begin
        state_nxt = sol_pkg::SOL_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= sol_pkg::SOL_ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Shared pins: inputs with pulls while in reset, outputs afterwards
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_pin_oe_o <= '0;
      strap_pin_o <= '0;
    end else begin
      strap_pin_oe_o <= {`SOL_NPIN{state_nxt == sol_pkg::SOL_ST_RUN}};
      strap_pin_o <= func_out_i;
    end
  end

  // Internally held strap values; only a release changes them
  logic [2:0] mode_w;
  logic mdix_w;
  assign mode_w = pin_s2_r[`SOL_PIN_MODE_HI:`SOL_PIN_MODE_LO];
  assign mdix_w = (mode_w == `SOL_MODE_MDIX_A) || (mode_w == `SOL_MODE_MDIX_B);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mgmt_addr_o <= {`SOL_ADDR_UPPER, `SOL_ADDR_DEF};
      mode_o <= `SOL_MODE_DEF;
      mdix_en_o <= 1'b0;
      mode_reserved_o <= 1'b0;
      test_tree_en_o <= 1'b0;
      filter_dis_o <= 1'b0;
      bcast_en_o <= 1'b1;
    end else if (release_w) begin
      mgmt_addr_o <= {`SOL_ADDR_UPPER, pin_s2_r[`SOL_PIN_ADDR_HI:`SOL_PIN_ADDR_LO]};
      mode_o <= mode_w;
      // Reserved codes fall back to crossover detection off
      mdix_en_o <= mdix_w;
      mode_reserved_o <= !mdix_w && (mode_w != `SOL_MODE_DEF);
      test_tree_en_o <= !pin_s2_r[`SOL_PIN_TREE];
      filter_dis_o <= pin_s2_r[`SOL_PIN_FILT];
      bcast_en_o <= !pin_s2_r[`SOL_PIN_BCST];
    end
  end

  // Management access: own address, or address 0 while broadcast is on
  logic hit_w;
  assign hit_w = mgmt_valid_i && (state_r == sol_pkg::SOL_ST_RUN) &&
                 ((mgmt_phy_i == mgmt_addr_o) ||
                  (bcast_en_o && (mgmt_phy_i == `SOL_BCAST_ADDR)));

  logic wr_ctrl_w;
  logic wr_adv_w;
  assign wr_ctrl_w = hit_w && mgmt_write_i && (mgmt_reg_i == `SOL_REG_CTRL);
  assign wr_adv_w = hit_w && mgmt_write_i && (mgmt_reg_i == `SOL_REG_ADV);

  // Control register: strap fields loaded at release, writable later
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      basic_control_o <= `SOL_CTRL_RST;
    end else if (release_w) begin
      basic_control_o[`SOL_CTRL_NEG] <= pin_s2_r[`SOL_PIN_NEG];
      basic_control_o[`SOL_CTRL_SPD] <= pin_s2_r[`SOL_PIN_SPD];
      basic_control_o[`SOL_CTRL_DPX] <= !pin_s2_r[`SOL_PIN_DPX];
    end else if (wr_ctrl_w) begin
      basic_control_o <= mgmt_wdata_i;
    end
  end

  // Advertisement: 100 Mbps abilities follow the speed strap
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      negotiation_advertisement_o <= `SOL_ADV_RST;
    end else if (release_w) begin
      negotiation_advertisement_o <= `SOL_ADV_BASE |
        (pin_s2_r[`SOL_PIN_SPD] ? `SOL_ADV_100_MASK : 16'h0000);
    end else if (wr_adv_w) begin
      negotiation_advertisement_o <= mgmt_wdata_i;
    end
  end

  // Read answer one cycle after a hit; unmapped registers read zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mgmt_ack_o <= 1'b0;
      mgmt_rdata_o <= 16'h0000;
    end else begin
      mgmt_ack_o <= hit_w;
      if (hit_w && !mgmt_write_i) begin
        case (mgmt_reg_i)
          `SOL_REG_CTRL: mgmt_rdata_o <= basic_control_o;
          `SOL_REG_ADV: mgmt_rdata_o <= negotiation_advertisement_o;
          default: mgmt_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_addr_latch;
    release_w |=> mgmt_addr_o[2:0] == $past(pin_s2_r[2:0]);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

  property p_addr_default;
    @(posedge clk_i) $fell(srst_i) |-> mgmt_addr_o == 5'h01;
  endproperty
  a_addr_default: assert property (p_addr_default) else $error("bad default address");

  property p_addr_upper;
    mgmt_addr_o[4:3] == 2'h0;
  endproperty
  a_addr_upper: assert property (p_addr_upper) else $error("upper address bits set");

  property p_mode;
    release_w |=> mode_o == $past(mode_w) &&
      mdix_en_o == ($past(mode_w) == 3'h2 || $past(mode_w) == 3'h6);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");

  property p_mode_default;
    $rose(state_r == sol_pkg::SOL_ST_RUN) && mode_o == 3'h0 |-> !mdix_en_o;
  endproperty
  a_mode_default: assert property (p_mode_default) else $error("mode 0 enabled crossover");

  property p_neg;
    release_w |=> basic_control_o[12] == $past(pin_s2_r[6]);
  endproperty
  a_neg: assert property (p_neg) else $error("negotiation bit wrong");

  property p_tree_filt;
    release_w |=> test_tree_en_o == !$past(pin_s2_r[7]) &&
      filter_dis_o == $past(pin_s2_r[8]);
  endproperty
  a_tree_filt: assert property (p_tree_filt) else $error("tree or filter wrong");

  property p_speed;
    release_w |=> basic_control_o[13] == $past(pin_s2_r[9]) &&
      negotiation_advertisement_o[8:7] == {2{$past(pin_s2_r[9])}};
  endproperty
  a_speed: assert property (p_speed) else $error("speed not loaded");

  property p_duplex;
    release_w |=> basic_control_o[8] != $past(pin_s2_r[10]);
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex not inverted");

  property p_bcast;
    release_w |=> bcast_en_o == !$past(pin_s2_r[11]);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast wrong");

  property p_pins_in;
    !rst_s2_r |=> strap_pin_oe_o == 12'h000;
  endproperty
  a_pins_in: assert property (p_pins_in) else $error("pin driven in reset");

  property p_sample_edge;
    $rose(rst_s2_r) |-> release_w;
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("release missed");

  property p_hold;
    !release_w |=> $stable(mgmt_addr_o) && $stable(bcast_en_o) && $stable(mode_o);
  endproperty
  a_hold: assert property (p_hold) else $error("held strap changed");

  property p_answer;
    mgmt_valid_i && state_r == sol_pkg::SOL_ST_RUN &&
      (mgmt_phy_i == mgmt_addr_o || (bcast_en_o && mgmt_phy_i == 5'h00)) |=> mgmt_ack_o;
  endproperty
  a_answer: assert property (p_answer) else $error("frame not answered");

  property p_no_answer;
    mgmt_valid_i && mgmt_phy_i == 5'h00 && !bcast_en_o && mgmt_addr_o != 5'h00 |=> !mgmt_ack_o;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("answered address 0");

endmodule : sol_top

/* tb/sol_board.sv */
// Board strap resistors and internal pin pulls on the shared strap pins
`timescale 1ns/10ps
`include "sol_defs.svh"

module sol_board (
  input wire logic [`SOL_NPIN-1:0] strap_en_i,
  input wire logic [`SOL_NPIN-1:0] strap_val_i,
  input wire logic [`SOL_NPIN-1:0] pin_out_i,
  input wire logic [`SOL_NPIN-1:0] pin_oe_i,
  output logic [`SOL_NPIN-1:0] pin_level_o
);
  // Internal pulls where no board resistor is fitted
  localparam logic [`SOL_NPIN-1:0] PULL_DEF = 12'h6C1;
  // The bench only fits legal mode codes on the board
  always_comb begin
    for (int k = 0; k < `SOL_NPIN; k++) begin
      pin_level_o[k] = pin_oe_i[k] ? pin_out_i[k] :
        (strap_en_i[k] ? strap_val_i[k] : PULL_DEF[k]);
    end
  end
endmodule : sol_board

/* tb/sol_top_tb_top.sv */
// Self-checking bench for the strap option latch
`timescale 1ns/10ps
`include "sol_defs.svh"

module sol_top_tb_top;
  logic clk_i = 0, srst_i = 1, chip_reset_n_i = 1;
  logic [11:0] pin_lvl, pin_o, pin_oe, strap_en = 12'h0, strap_val = 12'h0;
  logic [11:0] func_out = 12'hA5C;
  logic mv = 0, mw = 0, ack;
  logic [4:0] mphy = 5'h00, mreg = 5'h00, addr;
  logic [15:0] mwd = 16'h0000, rdata, ctrl, adv;
  logic [2:0] mode;
  logic rsv, mdix, tree, filt, bcst;
  int err_total = 0;
  int total_checks = 0;

  sol_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .chip_reset_n_i(chip_reset_n_i),
    .strap_pin_i(pin_lvl), .strap_pin_o(pin_o), .strap_pin_oe_o(pin_oe),
    .func_out_i(func_out), .mgmt_valid_i(mv), .mgmt_write_i(mw), .mgmt_phy_i(mphy),
    .mgmt_reg_i(mreg), .mgmt_wdata_i(mwd), .mgmt_ack_o(ack), .mgmt_rdata_o(rdata),
    .mgmt_addr_o(addr), .mode_o(mode), .mode_reserved_o(rsv), .mdix_en_o(mdix),
    .test_tree_en_o(tree), .filter_dis_o(filt), .bcast_en_o(bcst),
    .basic_control_o(ctrl), .negotiation_advertisement_o(adv));
  sol_board i_board (.strap_en_i(strap_en), .strap_val_i(strap_val), .pin_out_i(pin_o),
    .pin_oe_i(pin_oe), .pin_level_o(pin_lvl));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Waits for the pins to turn to outputs, which marks a finished latch
  task automatic await_oe;
    int n;
    for (n = 0; n < 10 && pin_oe !== 12'hFFF; n++) begin
      tick;
    end
    if (pin_oe !== 12'hFFF) begin
      err_total++;
      close_out;
    end
  endtask : await_oe

  task automatic check_latch;
    logic [11:0] p;
    logic [2:0] m;
    p = (strap_en & strap_val) | (~strap_en & 12'h6C1);
    m = p[5:3];
    chk("addr", {11'h0, addr}, {13'h0, p[2:0]});
    chk("flags", {8'h0, mode, rsv, mdix, tree, filt, bcst},
      {8'h0, m, 1'b0, m == 3'h2 || m == 3'h6, !p[7], p[8], !p[11]});
    chk("ctrl", ctrl, {2'h0, p[9], p[6], 3'h0, !p[10], 8'h00});
    chk("adv", adv, p[9] ? 16'h01E1 : 16'h0061);
    tick;
    chk("pin_out", {4'h0, pin_o}, {4'h0, func_out});
    // A new output value must reach the pins one cycle later; only the pins are checked here, not the latch
    func_out = ~func_out;
    tick;
    chk("pin_out_next", {4'h0, pin_o}, {4'h0, func_out});
  endtask : check_latch

  task automatic relatch(input logic [11:0] en, input logic [11:0] val);
    logic [4:0] a;
    a = addr;
    strap_en = en;
    strap_val = val;
    chip_reset_n_i = 0;
    repeat (6) tick;
    chk("oe_low", {4'h0, pin_oe}, 16'h0000);
    chk("addr_hold", {11'h0, addr}, {11'h0, a});
    chip_reset_n_i = 1;
    await_oe;
    check_latch;
  endtask : relatch

  task automatic mg(input logic wr, input logic [4:0] phy, input logic [4:0] rg,
    input logic [15:0] wd, input logic ex_ack, input logic [15:0] ex_rd);
    mv = 1;
    mw = wr;
    mphy = phy;
    mreg = rg;
    mwd = wd;
    tick;
    mv = 0;
    chk("ack", {15'h0, ack}, {15'h0, ex_ack});
    if (ex_ack && !wr) chk("rdata", rdata, ex_rd);
    // Idle cycle so the next call never raises valid in this time step
    tick;
  endtask : mg

  // Own address, broadcast address, a foreign address and an unmapped register
  task automatic mgmt_test;
    mg(1'b0, 5'h01, `SOL_REG_CTRL, 16'h0000, 1'b1, 16'h3000);
    mg(1'b1, 5'h00, `SOL_REG_ADV, 16'h1234, 1'b1, 16'h0000);
    mg(1'b0, 5'h01, `SOL_REG_ADV, 16'h0000, 1'b1, 16'h1234);
    mg(1'b0, 5'h01, 5'h02, 16'h0000, 1'b1, 16'h0000);
    mg(1'b0, 5'h03, `SOL_REG_CTRL, 16'h0000, 1'b0, 16'h0000);
  endtask : mgmt_test

  initial begin
    repeat (10) tick;
    srst_i = 0;
    await_oe;
    check_latch;
    mgmt_test;
    relatch(12'hFFF, 12'hA47);
    mg(1'b0, 5'h00, `SOL_REG_CTRL, 16'h0000, 1'b0, 16'h0000);
    mg(1'b0, 5'h07, `SOL_REG_CTRL, 16'h0000, 1'b1, 16'h3100);
    relatch(12'hFFF, 12'h590);
    relatch(12'hFFF, 12'h0F5);
    mg(1'b0, 5'h00, `SOL_REG_CTRL, 16'h0000, 1'b1, 16'h1100);
    relatch(12'h000, 12'h000);
    close_out;
  end
endmodule : sol_top_tb_top
